//--- lvs_pkg.sv
// Package: register map and field layout of the LED voltage sample registers
package lvs_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 9;
	localparam int unsigned SMP_W = 8;
	localparam logic [4:0] ADDR_CH1_NEWEST = 5'h0a;
	localparam logic [4:0] ADDR_CH1_ON = 5'h0b;
	localparam logic [4:0] ADDR_CH1_OFF = 5'h0c;
	localparam logic [4:0] ADDR_CH2_NEWEST = 5'h0d;
	localparam logic [4:0] ADDR_CH2_ON = 5'h0e;
	localparam logic [4:0] ADDR_CH2_OFF = 5'h0f;
	localparam logic [4:0] ADDR_SOFT_RESET = 5'h10;
	localparam int unsigned DIM_BIT = 8;
	localparam logic [8:0] SOFT_RESET_KEY = 9'h0c3;
	localparam logic [8:0] SAMPLE_RESET = 9'h000;
	localparam logic [8:0] READ_ZERO = 9'h000;
endpackage : lvs_pkg

//--- lvs_sample_regs.sv
// LED voltage sample registers for two channels, with soft-reset key register
// Behaviour
// [RL1] Channel 1 on-phase register keeps the newest sample seen before each falling dim edge.
// [RL2] Channel 1 off-phase register keeps the newest sample seen before each rising dim edge.
// [RL3] Channel 2 newest register holds the latest conversion and the dim level at its start.
// [RL4] Channel 2 on-phase register keeps the newest sample seen before each falling dim edge.
// [RL5] Channel 2 off-phase register keeps the newest sample seen before each rising dim edge.
// [RL6] Bit 8 of the four edge registers reads zero and all sample registers clear on reset.
// [RL7] Writing the key to the soft-reset register resets writable registers, other values not.
// [RL8] The soft-reset register always reads back zero.
// [RL9] Channel 1 newest register holds the latest conversion and the dim level at its start.
// [RL10] Host writes to sample registers are ignored.
// [RL11] On a dim edge the newest sample from just before the edge is copied that same cycle.
`timescale 1ns/100ps
module lvs_sample_regs (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [1:0] i_dim_input,
	input wire logic [1:0] i_conv_start,
	input wire logic [1:0] i_conv_done,
	input wire logic [lvs_pkg::SMP_W-1:0] i_conv_data_ch1,
	input wire logic [lvs_pkg::SMP_W-1:0] i_conv_data_ch2,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [lvs_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [lvs_pkg::DATA_W-1:0] i_reg_wdata,
	output logic [lvs_pkg::DATA_W-1:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_soft_reset
);
	import lvs_pkg::*;

	logic [1:0] dim_meta_r;
	logic [1:0] dim_sync_r;
	logic [1:0] dim_prev_r;
	logic [1:0] dim_at_start_r;
	logic [SMP_W-1:0] newest_r [2];
	logic [1:0] newest_dim_r;
	logic [SMP_W-1:0] on_phase_r [2];
	logic [SMP_W-1:0] off_phase_r [2];
	logic soft_reset_hit;
	logic [DATA_W-1:0] rdata_nxt;

	// Writes to any sample address fall through here and are dropped
	assign soft_reset_hit = i_reg_wr && (i_reg_addr == ADDR_SOFT_RESET)
		&& (i_reg_wdata == SOFT_RESET_KEY); // [RL7] [RL10]

	// Dim pins are asynchronous to the core clock
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			dim_meta_r <= 2'h0;
			dim_sync_r <= 2'h0;
			dim_prev_r <= 2'h0;
		end else begin
			dim_meta_r <= i_dim_input;
			dim_sync_r <= dim_meta_r;
			dim_prev_r <= dim_sync_r;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic [SMP_W-1:0] conv_data;
			assign conv_data = (ch == 0) ? i_conv_data_ch1 : i_conv_data_ch2;

			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					dim_at_start_r[ch] <= 1'b0;
				end else if (i_conv_start[ch]) begin
					dim_at_start_r[ch] <= dim_sync_r[ch]; // [RL3] [RL9]
				end
			end

			// Free running, not tied to dim edges
			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					newest_r[ch] <= SAMPLE_RESET[SMP_W-1:0]; // [RL6]
					newest_dim_r[ch] <= 1'b0;
				end else if (i_conv_done[ch]) begin
					newest_r[ch] <= conv_data; // [RL3] [RL9]
					newest_dim_r[ch] <= i_conv_start[ch] ? dim_sync_r[ch] : dim_at_start_r[ch];
				end
			end

			// Old newest_r value is taken, so a conversion finishing on the edge cycle is not used
			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					on_phase_r[ch] <= SAMPLE_RESET[SMP_W-1:0]; // [RL6]
					off_phase_r[ch] <= SAMPLE_RESET[SMP_W-1:0];
				end else begin
					if (dim_prev_r[ch] && !dim_sync_r[ch]) begin
						on_phase_r[ch] <= newest_r[ch]; // [RL1] [RL4] [RL11]
					end
					if (!dim_prev_r[ch] && dim_sync_r[ch]) begin
						off_phase_r[ch] <= newest_r[ch]; // [RL2] [RL5] [RL11]
					end
				end
			end
		end
	endgenerate

	always_comb begin
		case (i_reg_addr)
			ADDR_CH1_NEWEST: rdata_nxt = {newest_dim_r[0], newest_r[0]}; // [RL9]
			ADDR_CH1_ON: rdata_nxt = {1'b0, on_phase_r[0]}; // [RL6]
			ADDR_CH1_OFF: rdata_nxt = {1'b0, off_phase_r[0]};
			ADDR_CH2_NEWEST: rdata_nxt = {newest_dim_r[1], newest_r[1]}; // [RL3]
			ADDR_CH2_ON: rdata_nxt = {1'b0, on_phase_r[1]};
			ADDR_CH2_OFF: rdata_nxt = {1'b0, off_phase_r[1]};
			ADDR_SOFT_RESET: rdata_nxt = READ_ZERO; // [RL8]
			default: rdata_nxt = READ_ZERO;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_reg_rdata <= READ_ZERO;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rdata <= i_reg_rd ? rdata_nxt : READ_ZERO;
			o_reg_rvalid <= i_reg_rd;
		end
	end

	// Pulse to the writable registers elsewhere in the device
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= soft_reset_hit; // [RL7]
		end
	end
endmodule : lvs_sample_regs

//--- lvs_chk.sv
// Port assertions for the LED voltage sample registers
`timescale 1ns/100ps
module lvs_chk (
	input logic i_core_clk,
	input logic i_srst,
	input logic i_reg_wr,
	input logic i_reg_rd,
	input logic o_reg_rvalid,
	input logic o_soft_reset,
	input logic [4:0] i_reg_addr,
	input logic [8:0] i_reg_wdata,
	input logic [8:0] o_reg_rdata
);
	import lvs_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	wire r = i_reg_rd;
	wire [4:0] a = i_reg_addr;
	wire k = i_reg_wr && a == ADDR_SOFT_RESET && i_reg_wdata == SOFT_RESET_KEY;
	AST_RV: assert property (r |=> o_reg_rvalid) else $error("rv");
	AST_NRV: assert property (!r |=> !o_reg_rvalid) else $error("nrv");
	AST_KEY: assert property (k |=> o_soft_reset) else $error("key");
	AST_NKEY: assert property (!k |=> !o_soft_reset) else $error("nkey");
	AST_RZ: assert property (r && a == ADDR_SOFT_RESET |=> o_reg_rdata == 0) else $error("rz");
	AST_RSV: assert property (r && a > 5'h0a && a < 5'h10 && a != 5'h0d |=> !o_reg_rdata[8])
		else $error("rsv");
	AST_IDL: assert property (!r |=> o_reg_rdata == 0) else $error("idl");
	AST_UNM: assert property (r && a < 5'h0a |=> o_reg_rdata == 0) else $error("unm");
	cover property (k ##1 o_soft_reset);
	cover property (r && a == ADDR_CH1_ON ##1 o_reg_rdata != 0);
	cover property (r && a == ADDR_CH2_NEWEST ##1 o_reg_rdata[8]);
endmodule : lvs_chk
bind lvs_sample_regs lvs_chk chk_u (.*);

//--- lvs_host.sv
// Host model issuing register strobes
`timescale 1ns/100ps
module lvs_host (
	input logic i_clk,
	input logic [8:0] i_rdata,
	input logic i_rvalid,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0,
	output logic [4:0] o_addr = 5'h00,
	output logic [8:0] o_wdata = 9'h000
);
	// Strobe stands for one taking edge; answer taken at the next edge, while it stands
	task acc(input logic w, input logic [4:0] a, input logic [8:0] d, output logic [8:0] q,
		output logic vld);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		// Strobes dropped, address and data inverted so stale values never look valid
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		@(posedge i_clk);
		q = i_rdata;
		vld = i_rvalid;
	endtask : acc
endmodule : lvs_host

//--- lvs_sample_regs_tb_top.sv
// Self-checking bench for the LED voltage sample registers
`timescale 1ns/100ps
module lvs_sample_regs_tb_top;
	import lvs_pkg::*;
	logic clk = 0, srst = 1, wr, rd, rv, sr;
	logic [1:0] dim = 0, cs = 0, cd = 0;
	logic [7:0] d1 = 0, d2 = 0;
	logic [4:0] ad;
	logic [8:0] wd, q, v;
	logic [8:0] ex [8] = '{9'h000, 9'h13c, 9'h03c, 9'h05a, 9'h1c3, 9'h0c3, 9'h0a5, 9'h000};
	int n_fail = 0, compares = 0;
	initial forever #2.5 clk = ~clk;
	lvs_host h (.i_clk(clk), .i_rdata(q), .i_rvalid(rv), .o_wr(wr), .o_rd(rd), .o_addr(ad),
		.o_wdata(wd));
	lvs_sample_regs dut_u (.i_core_clk(clk), .i_srst(srst), .i_dim_input(dim), .i_conv_start(cs),
		.i_conv_done(cd), .i_conv_data_ch1(d1), .i_conv_data_ch2(d2), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(q), .o_reg_rvalid(rv),
		.o_soft_reset(sr));
	task cmp(input string nm, input logic [8:0] e, input logic [8:0] s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask : cmp
	// Read: data and rvalid are looked at in the one cycle they stand
	task ck(input logic [4:0] a, input logic [8:0] e);
		logic f;
		h.acc(1'b0, a, 9'h000, v, f);
		cmp($sformatf("reg %h", a), e, v);
		cmp($sformatf("rvalid %h", a), 9'h001, {8'h00, f});
	endtask : ck
	// Write: soft-reset pulse is still standing when the access returns
	task wk(input logic [4:0] a, input logic [8:0] d, input logic e);
		logic f;
		h.acc(1'b1, a, d, v, f);
		cmp("soft_reset", {8'h00, e}, {8'h00, sr});
	endtask : wk
	task report_and_stop;
		$display("compares %0d, n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		// Tests need well under a thousand cycles; this allows ample margin
		#20000 n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 0;
		foreach (ex[i]) ck(5'h09 + 5'(i), 9'h000);
		@(posedge clk) {cs, cd, d1, d2} <= 20'hf5aa5;
		@(posedge clk) {cs, cd, dim} <= 6'h03;
		repeat (6) @(posedge clk);
		@(posedge clk) {cs, cd, d1, d2} <= 20'hf3cc3;
		@(posedge clk) {cs, cd, dim} <= 6'h00;
		repeat (6) @(posedge clk);
		wk(ADDR_CH1_ON, 9'h1ff, 1'b0);
		wk(ADDR_SOFT_RESET, 9'h0c2, 1'b0);
		wk(ADDR_SOFT_RESET, SOFT_RESET_KEY, 1'b1);
		foreach (ex[i]) ck(5'h09 + 5'(i), ex[i]);
		// Conversion starts with dim low and ends with it high
		@(posedge clk) cs <= 2'b01;
		@(posedge clk) cs <= 2'b00;
		dim <= 2'b01;
		repeat (4) @(posedge clk);
		@(posedge clk) cd <= 2'b01;
		d1 <= 8'h77;
		@(posedge clk) cd <= 2'b00;
		ck(ADDR_CH1_NEWEST, 9'h077);
		ck(ADDR_CH1_OFF, 9'h03c);
		// Conversion ends on the capture cycle of the falling edge
		@(posedge clk) dim <= 2'b00;
		@(posedge clk);
		@(posedge clk) {cs, cd, d1} <= 12'h599;
		@(posedge clk) {cs, cd} <= 4'h0;
		ck(ADDR_CH1_ON, 9'h077);
		ck(ADDR_CH1_NEWEST, 9'h099);
		// Second reset clears values that are no longer zero
		@(posedge clk) srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		foreach (ex[i]) ck(5'h09 + 5'(i), 9'h000);
		report_and_stop;
	end
endmodule : lvs_sample_regs_tb_top
